// ==== core/rlm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - PCS lanes 0 to 19 each get a 5-bit physical lane index output.
// - 20-bit level output, bit set while that PCS lane is demultiplexed.
// - 3-bit one-cycle count of bad FCS packets, stomped excluded.
// - Received FCS equal to inverted computed FCS is stomped, not bad.
// - 3-bit one-cycle count of stomped FCS packets, back to back allowed.
// - Packet over configured 15-bit maximum is truncated with one-cycle pulse.
// - Local fault high while test pattern, bad alignment or high BER persist.
// - Lane index valid only while its sync bit is one.
// - Twenty separate level 5-bit lane index buses, lanes 0 to 19.
module rlm_top #(
   parameter int FCS_SLOTS = 2
) (
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   rst_n_i,
   // Lane marker detection, one entry per physical lane; sync flags one entry per PCS lane
   input  wire logic [`RLM_LANES-1:0]                  mark_vld_i,
   input  wire logic [`RLM_LANES-1:0][`RLM_LANE_W-1:0] mark_pcsl_i,
   input  wire logic [`RLM_LANES-1:0]                  synced_i,
   // Fault sources
   input  wire logic                                   test_pattern_i,
   input  wire logic                                   aligned_i,
   input  wire logic                                   hi_ber_i,
   // Packet beats
   input  wire logic                                   rx_vld_i,
   input  wire logic                                   rx_sop_i,
   input  wire logic                                   rx_eop_i,
   input  wire logic [`RLM_BYTES_W-1:0]                rx_bytes_i,
   input  wire logic [`RLM_DATA_W-1:0]                 rx_data_i,
   // Packet end FCS checks
   input  wire logic [FCS_SLOTS-1:0]                   fcs_vld_i,
   input  wire logic [FCS_SLOTS-1:0][`RLM_FCS_W-1:0]   fcs_rx_i,
   input  wire logic [FCS_SLOTS-1:0][`RLM_FCS_W-1:0]   fcs_calc_i,
   // Register port
   input  wire logic [`RLM_ADDR_W-1:0]                 reg_addr_i,
   input  wire logic [`RLM_REG_W-1:0]                  reg_wdata_i,
   input  wire logic                                   reg_wr_i,
   input  wire logic                                   reg_rd_i,
   output logic [`RLM_REG_W-1:0]                       reg_rdata_o,
   output logic                                        irq_o,
   // Packet output
   output logic                                        out_vld_o,
   output logic                                        out_sop_o,
   output logic                                        out_eop_o,
   output logic [`RLM_DATA_W-1:0]                      out_data_o,
   // Status
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_0_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_1_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_2_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_3_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_4_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_5_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_6_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_7_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_8_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_9_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_10_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_11_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_12_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_13_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_14_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_15_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_16_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_17_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_18_o,
   output logic [`RLM_LANE_W-1:0]                      pcsl_num_19_o,
   output logic [`RLM_LANES-1:0]                       pcsl_demuxed_o,
   output logic [`RLM_ERRCNT_W-1:0]                    bad_fcs_o,
   output logic [`RLM_ERRCNT_W-1:0]                    stomped_fcs_o,
   output logic                                        truncated_o,
   output logic                                        internal_local_fault_o
);

   rlm_pkg::rlm_top_st_t     st_q;
   rlm_pkg::rlm_top_st_t     st_d;
   logic [FCS_SLOTS-1:0]     slot_bad;
   logic [FCS_SLOTS-1:0]     slot_stomp;
   logic [`RLM_ERRCNT_W-1:0] bad_sum;
   logic [`RLM_ERRCNT_W-1:0] stomp_sum;
   logic [`RLM_IRQ_W-1:0]    irq_evt;
   logic [`RLM_IRQ_W-1:0]    irq_clr;
   logic                     fault_now;

   rlm_pkt_if pkt ();

   ////////////////////////////////////////////////////////////////////////////
   // FCS classification per packet end slot
   for (genvar g = 0; g < FCS_SLOTS; g++) begin : g_fcs
      rlm_fcs_check u_fcs (
         .vld_i      (fcs_vld_i[g]),
         .rx_fcs_i   (fcs_rx_i[g]),
         .calc_fcs_i (fcs_calc_i[g]),
         .bad_o      (slot_bad[g]),
         .stomp_o    (slot_stomp[g])
      );
   end

   always_comb begin
      bad_sum   = '0;
      stomp_sum = '0;
      for (int i = 0; i < FCS_SLOTS; i++) begin
         bad_sum   = bad_sum + `RLM_ERRCNT_W'(slot_bad[i]);
         stomp_sum = stomp_sum + `RLM_ERRCNT_W'(slot_stomp[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Length guard
   assign pkt.vld     = rx_vld_i;
   assign pkt.sop     = rx_sop_i;
   assign pkt.eop     = rx_eop_i;
   assign pkt.bytes   = rx_bytes_i;
   assign pkt.max_len = st_q.max_len;

   rlm_len_guard u_guard (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .pkt       (pkt.guard)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Fault and interrupt events
   assign fault_now = test_pattern_i || !aligned_i || hi_ber_i;

   always_comb begin
      irq_evt                 = '0;
      irq_evt[`RLM_IRQ_BAD]   = |bad_sum;
      irq_evt[`RLM_IRQ_STOMP] = |stomp_sum;
      irq_evt[`RLM_IRQ_TRUNC] = pkt.trunc;
      irq_evt[`RLM_IRQ_FAULT] = fault_now;
      irq_clr                 = '0;
      if (reg_wr_i && reg_addr_i == `RLM_OFS_IRQ_STS) begin
         irq_clr = reg_wdata_i[`RLM_IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      // Lane map update on marker, demux bit drop on sync loss
      for (int l = 0; l < `RLM_LANES; l++) begin
         if (!synced_i[l]) begin
            st_d.demux[l] = 1'b0;
         end
      end
      for (int p = 0; p < `RLM_LANES; p++) begin
         if (mark_vld_i[p] && (mark_pcsl_i[p] < `RLM_LANE_W'(`RLM_LANES))) begin
            if (synced_i[mark_pcsl_i[p]]) begin
               st_d.map[mark_pcsl_i[p]]   = `RLM_LANE_W'(p);
               st_d.demux[mark_pcsl_i[p]] = 1'b1;
            end
         end
      end
      // Pulses fall back to zero without events
      st_d.bad    = bad_sum;
      st_d.stomp  = stomp_sum;
      st_d.trunc  = pkt.trunc;
      st_d.lfault = fault_now;
      // Packet output
      st_d.out_vld  = pkt.keep;
      st_d.out_sop  = pkt.keep && rx_sop_i;
      st_d.out_eop  = pkt.keep && (rx_eop_i || pkt.force_eop);
      if (pkt.keep) begin
         st_d.out_data = rx_data_i;
      end
      // Sticky status, set wins over clear
      st_d.irq_sts = (st_q.irq_sts & ~irq_clr) | irq_evt;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `RLM_OFS_IRQ_MSK: st_d.irq_msk = reg_wdata_i[`RLM_IRQ_W-1:0];
            `RLM_OFS_MAX_LEN: st_d.max_len = reg_wdata_i[`RLM_LEN_W-1:0];
            default:          st_d.irq_msk = st_d.irq_msk;
         endcase
      end
      st_d.rdata = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `RLM_OFS_IRQ_STS: st_d.rdata = `RLM_REG_W'(st_q.irq_sts);
            `RLM_OFS_IRQ_MSK: st_d.rdata = `RLM_REG_W'(st_q.irq_msk);
            `RLM_OFS_MAX_LEN: st_d.rdata = `RLM_REG_W'(st_q.max_len);
            `RLM_OFS_DEMUXED: st_d.rdata = `RLM_REG_W'(st_q.demux);
            `RLM_OFS_FAULT:   st_d.rdata = `RLM_REG_W'(st_q.lfault);
            default:          st_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q         <= '0;
         st_q.max_len <= `RLM_MAXLEN_RST;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata_o            = st_q.rdata;
   assign irq_o                  = |(st_q.irq_sts & st_q.irq_msk);
   assign out_vld_o              = st_q.out_vld;
   assign out_sop_o              = st_q.out_sop;
   assign out_eop_o              = st_q.out_eop;
   assign out_data_o             = st_q.out_data;
   assign pcsl_demuxed_o         = st_q.demux;
   assign bad_fcs_o              = st_q.bad;
   assign stomped_fcs_o          = st_q.stomp;
   assign truncated_o            = st_q.trunc;
   assign internal_local_fault_o = st_q.lfault;
   // Index held while lane synced, meaningless otherwise
   assign pcsl_num_0_o           = st_q.map[0];
   assign pcsl_num_1_o           = st_q.map[1];
   assign pcsl_num_2_o           = st_q.map[2];
   assign pcsl_num_3_o           = st_q.map[3];
   assign pcsl_num_4_o           = st_q.map[4];
   assign pcsl_num_5_o           = st_q.map[5];
   assign pcsl_num_6_o           = st_q.map[6];
   assign pcsl_num_7_o           = st_q.map[7];
   assign pcsl_num_8_o           = st_q.map[8];
   assign pcsl_num_9_o           = st_q.map[9];
   assign pcsl_num_10_o          = st_q.map[10];
   assign pcsl_num_11_o          = st_q.map[11];
   assign pcsl_num_12_o          = st_q.map[12];
   assign pcsl_num_13_o          = st_q.map[13];
   assign pcsl_num_14_o          = st_q.map[14];
   assign pcsl_num_15_o          = st_q.map[15];
   assign pcsl_num_16_o          = st_q.map[16];
   assign pcsl_num_17_o          = st_q.map[17];
   assign pcsl_num_18_o          = st_q.map[18];
   assign pcsl_num_19_o          = st_q.map[19];

endmodule : rlm_top

`default_nettype wire

// ==== include/rlm_params.svh ====
`ifndef RLM_PARAMS_SVH
`define RLM_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Lane map geometry
`define RLM_LANES        20
`define RLM_LANE_W       5

////////////////////////////////////////////////////////////////////////////////
// Packet path
`define RLM_DATA_W       512
`define RLM_BYTES_W      7
`define RLM_LEN_W        15
`define RLM_CNT_W        16
`define RLM_FCS_W        32
`define RLM_ERRCNT_W     3
`define RLM_MAXLEN_RST   15'h2580

////////////////////////////////////////////////////////////////////////////////
// Register port
`define RLM_ADDR_W       8
`define RLM_REG_W        32
`define RLM_OFS_IRQ_STS  8'h00
`define RLM_OFS_IRQ_MSK  8'h04
`define RLM_OFS_MAX_LEN  8'h08
`define RLM_OFS_DEMUXED  8'h0C
`define RLM_OFS_FAULT    8'h10

////////////////////////////////////////////////////////////////////////////////
// Interrupt bits
`define RLM_IRQ_W        4
`define RLM_IRQ_BAD      0
`define RLM_IRQ_STOMP    1
`define RLM_IRQ_TRUNC    2
`define RLM_IRQ_FAULT    3

`endif

// ==== include/rlm_pkg.sv ====
`include "rlm_params.svh"

package rlm_pkg;

   typedef logic [`RLM_LANES-1:0][`RLM_LANE_W-1:0] rlm_map_t;

   typedef struct packed {
      logic [`RLM_CNT_W-1:0] len;
      logic                  drop;
   } rlm_guard_st_t;

   typedef struct packed {
      rlm_map_t                 map;
      logic [`RLM_LANES-1:0]    demux;
      logic [`RLM_ERRCNT_W-1:0] bad;
      logic [`RLM_ERRCNT_W-1:0] stomp;
      logic                     trunc;
      logic                     lfault;
      logic [`RLM_IRQ_W-1:0]    irq_sts;
      logic [`RLM_IRQ_W-1:0]    irq_msk;
      logic [`RLM_LEN_W-1:0]    max_len;
      logic [`RLM_REG_W-1:0]    rdata;
      logic                     out_vld;
      logic                     out_sop;
      logic                     out_eop;
      logic [`RLM_DATA_W-1:0]   out_data;
   } rlm_top_st_t;

endpackage : rlm_pkg

// ==== include/rlm_pkt_if.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

interface rlm_pkt_if;
   logic                    vld;
   logic                    sop;
   logic                    eop;
   logic [`RLM_BYTES_W-1:0] bytes;
   logic [`RLM_LEN_W-1:0]   max_len;
   logic                    keep;
   logic                    force_eop;
   logic                    trunc;

   modport guard (input vld, sop, eop, bytes, max_len, output keep, force_eop, trunc);
   modport user  (output vld, sop, eop, bytes, max_len, input keep, force_eop, trunc);
endinterface : rlm_pkt_if

`default_nettype wire

// ==== core/rlm_fcs_check.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

module rlm_fcs_check (
   input  wire logic                  vld_i,
   input  wire logic [`RLM_FCS_W-1:0] rx_fcs_i,
   input  wire logic [`RLM_FCS_W-1:0] calc_fcs_i,
   output logic                       bad_o,
   output logic                       stomp_o
);

   logic stomp_match;

   // Inverted good FCS marks a stomped frame
   assign stomp_match = (rx_fcs_i == ~calc_fcs_i);
   assign stomp_o     = vld_i && stomp_match;
   assign bad_o       = vld_i && (rx_fcs_i != calc_fcs_i) && !stomp_match;

endmodule : rlm_fcs_check

`default_nettype wire

// ==== core/rlm_len_guard.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

module rlm_len_guard (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   rlm_pkt_if.guard  pkt
);

   rlm_pkg::rlm_guard_st_t st_q;
   rlm_pkg::rlm_guard_st_t st_d;
   logic [`RLM_CNT_W-1:0]  base;
   logic [`RLM_CNT_W-1:0]  sum;
   logic                   drop_now;

   always_comb begin
      st_d          = st_q;
      base          = pkt.sop ? '0 : st_q.len;
      sum           = base + `RLM_CNT_W'(pkt.bytes);
      drop_now      = st_q.drop && !pkt.sop;
      pkt.keep      = pkt.vld && !drop_now;
      // First beat past the limit ends the packet
      pkt.trunc     = pkt.keep && (sum > `RLM_CNT_W'(pkt.max_len));
      pkt.force_eop = pkt.trunc;
      if (pkt.vld) begin
         st_d.len  = sum;
         st_d.drop = (drop_now || pkt.trunc) && !pkt.eop;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule : rlm_len_guard

`default_nettype wire

// ==== tb/rlm_fabric_model.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

module rlm_fabric_model (
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   rst_n_i,
   input  wire logic [`RLM_LANES-1:0]                  synced_i,
   input  wire logic [`RLM_LANES-1:0][`RLM_LANE_W-1:0] num_i,
   input  wire logic [`RLM_ERRCNT_W-1:0]               bad_i,
   input  wire logic [`RLM_ERRCNT_W-1:0]               stomp_i,
   input  wire logic                                   trunc_i,
   output logic [`RLM_LANES-1:0][`RLM_LANE_W-1:0]      map_o,
   output logic [15:0]                                 bad_sum_o,
   output logic [15:0]                                 stomp_sum_o,
   output logic [15:0]                                 trunc_sum_o
);
   // Lane view and running event totals
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         map_o <= '0;
         bad_sum_o <= 16'h0;
         stomp_sum_o <= 16'h0;
         trunc_sum_o <= 16'h0;
      end else begin
         for (int l = 0; l < `RLM_LANES; l++) begin
            if (synced_i[l]) begin
               map_o[l] <= num_i[l];
            end
         end
         bad_sum_o <= bad_sum_o + 16'(bad_i);
         stomp_sum_o <= stomp_sum_o + 16'(stomp_i);
         trunc_sum_o <= trunc_sum_o + 16'(trunc_i);
      end
   end
endmodule : rlm_fabric_model

`default_nettype wire

// ==== tb/rlm_top_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

module rlm_monitor #(
   parameter int FCS_SLOTS = 2
) (
   input wire logic                                   clk_sys_i,
   input wire logic                                   rst_n_i,
   input wire logic [`RLM_LANES-1:0]                  mark_vld_i,
   input wire logic [`RLM_LANES-1:0][`RLM_LANE_W-1:0] mark_pcsl_i,
   input wire logic [`RLM_LANES-1:0]                  synced_i,
   input wire logic                                   test_pattern_i,
   input wire logic                                   aligned_i,
   input wire logic                                   hi_ber_i,
   input wire logic [FCS_SLOTS-1:0]                   fcs_vld_i,
   input wire logic [FCS_SLOTS-1:0][`RLM_FCS_W-1:0]   fcs_rx_i,
   input wire logic [FCS_SLOTS-1:0][`RLM_FCS_W-1:0]   fcs_calc_i,
   input wire logic                                   out_vld_o,
   input wire logic                                   out_sop_o,
   input wire logic                                   out_eop_o,
   input wire logic [`RLM_LANE_W-1:0]                 pcsl_num_7_o,
   input wire logic [`RLM_LANES-1:0]                  pcsl_demuxed_o,
   input wire logic [`RLM_ERRCNT_W-1:0]               bad_fcs_o,
   input wire logic [`RLM_ERRCNT_W-1:0]               stomped_fcs_o,
   input wire logic                                   truncated_o,
   input wire logic                                   internal_local_fault_o
);
   logic [`RLM_ERRCNT_W-1:0] n_bad;
   logic [`RLM_ERRCNT_W-1:0] n_stomp;
   logic                     fault_src;

   assign fault_src = test_pattern_i || !aligned_i || hi_ber_i;

   // Expected counts per cycle
   always_comb begin
      n_bad = '0;
      n_stomp = '0;
      for (int s = 0; s < FCS_SLOTS; s++) begin
         if (fcs_vld_i[s] && fcs_rx_i[s] == ~fcs_calc_i[s]) begin
            n_stomp = n_stomp + 3'h1;
         end else if (fcs_vld_i[s] && fcs_rx_i[s] != fcs_calc_i[s]) begin
            n_bad = n_bad + 3'h1;
         end
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_cut; truncated_o; endsequence
   sequence s_gap; !out_vld_o || out_sop_o; endsequence

   lane_claim_a:
   assert property (mark_vld_i[19] && mark_pcsl_i[19] == 5'h07 && synced_i[7]
      |=> pcsl_num_7_o == 5'h13) else $error("lane 7 index wrong");
   demux_set_a:
   assert property (mark_vld_i[19] && mark_pcsl_i[19] < 5'h14 && synced_i[mark_pcsl_i[19]]
      |=> pcsl_demuxed_o[$past(mark_pcsl_i[19])]) else $error("demux bit not set");
   demux_drop_a:
   assert property (!synced_i[7] |=> !pcsl_demuxed_o[7]) else $error("demux bit stuck");
   fcs_quiet_a:
   assert property (fcs_vld_i == '0 |=> bad_fcs_o == 3'h0 && stomped_fcs_o == 3'h0)
      else $error("fcs count without event");
   fcs_count_a:
   assert property (fcs_vld_i != '0 |=> bad_fcs_o == $past(n_bad)
      && stomped_fcs_o == $past(n_stomp)) else $error("fcs count wrong");
   trunc_eop_a:
   assert property (s_cut |-> out_vld_o && out_eop_o) else $error("truncation without end");
   trunc_drop_a:
   assert property (s_cut |=> s_gap) else $error("beat after truncation");
   fault_set_a:
   assert property (fault_src |=> internal_local_fault_o) else $error("fault not raised");
   fault_clear_a:
   assert property (!fault_src |=> !internal_local_fault_o) else $error("fault not cleared");
endmodule : rlm_monitor

bind rlm_top rlm_monitor #(.FCS_SLOTS(FCS_SLOTS)) u_mon (.clk_sys_i, .rst_n_i, .mark_vld_i,
   .mark_pcsl_i, .synced_i, .test_pattern_i, .aligned_i, .hi_ber_i, .fcs_vld_i, .fcs_rx_i,
   .fcs_calc_i, .out_vld_o, .out_sop_o, .out_eop_o, .pcsl_num_7_o, .pcsl_demuxed_o,
   .bad_fcs_o, .stomped_fcs_o, .truncated_o, .internal_local_fault_o);

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rlm_params.svh"

module testbench;
   localparam int NS = 2;
   localparam int MAXL = 32'h64;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [19:0] mark_vld, synced, demux;
   logic [19:0][4:0] mark_pcsl, map;
   wire logic [19:0][4:0] num;
   logic tp, aligned, ber, rx_vld, rx_sop, rx_eop, wr, rd, irq, o_vld, o_sop, o_eop, trunc, fault;
   logic [6:0] rx_bytes;
   logic [511:0] rx_data, o_data, pd, nd;
   logic [NS-1:0] fcs_vld;
   logic [NS-1:0][31:0] fcs_rx, fcs_calc;
   logic [NS-1:0][1:0] kd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d, cv;
   logic [2:0] bad, stomp, eb, es;
   logic [15:0] bad_sum, stomp_sum, trunc_sum;
   int n_mismatch, samples_checked, tot_bad, tot_stomp, tot_trunc, seed;

   always #5 clk_sys_i = ~clk_sys_i;

   rlm_top #(.FCS_SLOTS(NS)) u_dut (.clk_sys_i, .rst_n_i, .mark_vld_i(mark_vld),
      .mark_pcsl_i(mark_pcsl), .synced_i(synced), .test_pattern_i(tp), .aligned_i(aligned),
      .hi_ber_i(ber), .rx_vld_i(rx_vld), .rx_sop_i(rx_sop), .rx_eop_i(rx_eop),
      .rx_bytes_i(rx_bytes), .rx_data_i(rx_data), .fcs_vld_i(fcs_vld), .fcs_rx_i(fcs_rx),
      .fcs_calc_i(fcs_calc), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq), .out_vld_o(o_vld), .out_sop_o(o_sop),
      .out_eop_o(o_eop), .out_data_o(o_data), .pcsl_num_0_o(num[0]), .pcsl_num_1_o(num[1]),
      .pcsl_num_2_o(num[2]), .pcsl_num_3_o(num[3]), .pcsl_num_4_o(num[4]),
      .pcsl_num_5_o(num[5]), .pcsl_num_6_o(num[6]), .pcsl_num_7_o(num[7]),
      .pcsl_num_8_o(num[8]), .pcsl_num_9_o(num[9]), .pcsl_num_10_o(num[10]),
      .pcsl_num_11_o(num[11]), .pcsl_num_12_o(num[12]), .pcsl_num_13_o(num[13]),
      .pcsl_num_14_o(num[14]), .pcsl_num_15_o(num[15]), .pcsl_num_16_o(num[16]),
      .pcsl_num_17_o(num[17]), .pcsl_num_18_o(num[18]), .pcsl_num_19_o(num[19]),
      .pcsl_demuxed_o(demux), .bad_fcs_o(bad), .stomped_fcs_o(stomp), .truncated_o(trunc),
      .internal_local_fault_o(fault));

   rlm_fabric_model u_fabric (.clk_sys_i, .rst_n_i, .synced_i(synced), .num_i(num),
      .bad_i(bad), .stomp_i(stomp), .trunc_i(trunc), .map_o(map), .bad_sum_o(bad_sum),
      .stomp_sum_o(stomp_sum), .trunc_sum_o(trunc_sum));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1 chk("reg_rdata_o", e, rdata);
   endtask : reg_rd

   function automatic logic [2:0] fcs_expect(input logic [NS-1:0] v,
                                             input logic [NS-1:0][1:0] k, input logic [1:0] w);
      fcs_expect = 3'h0;
      for (int s = 0; s < NS; s++) begin
         if (v[s] && k[s] == w) fcs_expect = fcs_expect + 3'h1;
      end
   endfunction : fcs_expect

   // Beats of one packet, output of beat k checked at edge k+1
   task automatic run_pkt(input int beats, input int b);
      int sum;
      logic cut, pv, pe, pt;
      sum = 0;
      cut = 1'b0;
      for (int k = 0; k <= beats; k++) begin
         @(posedge clk_sys_i);
         rx_vld <= (k < beats);
         rx_sop <= (k == 0);
         rx_eop <= (k == beats - 1);
         rx_bytes <= 7'(b);
         nd = {16{$urandom}};
         rx_data <= nd;
         #1;
         if (k > 0) begin
            chk("out_vld_o", 32'(pv), 32'(o_vld));
            chk("out_sop_o", 32'(pv && k == 1), 32'(o_sop));
            chk("out_data_o", 32'h0, 32'(o_data != pd));
            chk("out_eop_o", 32'(pe), 32'(o_eop));
            chk("truncated_o", 32'(pt), 32'(trunc));
         end
         sum += b;
         pv = !cut && k < beats;
         if (pv) pd = nd;
         pt = pv && sum > MAXL;
         pe = pv && (pt || k == beats - 1);
         cut = cut || pt;
         tot_trunc += 32'(pt);
      end
   endtask : run_pkt

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      seed = $urandom(55);
      {mark_vld, mark_pcsl, tp, ber, rx_vld, rx_sop, rx_eop, rx_bytes, rx_data} = '0;
      {fcs_vld, fcs_rx, fcs_calc, addr, wdata, wr, rd, eb, es} = '0;
      synced = '1;
      aligned = 1'b1;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      reg_rd(8'h08, 32'h2580);
      reg_rd(8'h20, 32'h0);
      // Lane map, every PCS lane from a random physical lane, except lane 7 and, on the final pass, lane 0 from physical lane 19
      for (int l = 0; l <= 20; l++) begin
         @(posedge clk_sys_i);
         d = (l == 20 || l == 7) ? 32'h13 : 32'($urandom_range(19));
         mark_vld <= (l == 20) ? 20'h80010 : 20'h1 << d;
         for (int p = 0; p < 20; p++) mark_pcsl[p] <= 5'(l % 20);
         @(posedge clk_sys_i);
         mark_vld <= '0;
         #1 chk("pcsl_num", d, 32'(num[l % 20]));
         chk("pcsl_demuxed_o", 32'h1, 32'(demux[l % 20]));
      end
      @(posedge clk_sys_i);
      synced[7] <= 1'b0;
      mark_vld <= 20'h4;
      mark_pcsl[2] <= 5'h07;
      @(posedge clk_sys_i);
      mark_vld <= '0;
      @(posedge clk_sys_i);
      #1 chk("pcsl_demuxed_o", 32'h0, 32'(demux[7]));
      chk("pcsl_num_7_o", 32'h13, 32'(num[7]));
      for (int l = 0; l < 20; l++) chk("fabric_map", 32'(num[l]), 32'(map[l]));
      reg_rd(8'h0C, 32'hFFF7F);
      // FCS outcomes, back to back
      for (int i = 0; i <= 60; i++) begin
         @(posedge clk_sys_i);
         for (int s = 0; s < NS; s++) begin
            kd[s] = (i < 3) ? 2'(i) : 2'($urandom_range(2));
            cv = $urandom;
            fcs_calc[s] <= cv;
            fcs_rx[s] <= (kd[s] == 2'h0) ? cv : (kd[s] == 2'h1) ? cv ^ (32'h1 << s) : ~cv;
         end
         d = (i < 3) ? '1 : (i == 60) ? '0 : $urandom;
         fcs_vld <= d[NS-1:0];
         #1;
         if (i > 0) chk("bad_fcs_o", 32'(eb), 32'(bad));
         if (i > 0) chk("stomped_fcs_o", 32'(es), 32'(stomp));
         eb = fcs_expect(d[NS-1:0], kd, 2'h1);
         es = fcs_expect(d[NS-1:0], kd, 2'h2);
         tot_bad += 32'(eb);
         tot_stomp += 32'(es);
      end
      // Truncation against a small maximum
      reg_wr(8'h08, 32'h64);
      reg_rd(8'h08, 32'h64);
      run_pkt(2, 50);
      run_pkt(3, 64);
      run_pkt(1, 101);
      for (int j = 0; j < 12; j++) run_pkt($urandom_range(4, 1), $urandom_range(64, 1));
      @(posedge clk_sys_i);
      #1 chk("bad_sum", 32'(tot_bad), 32'(bad_sum));
      chk("stomp_sum", 32'(tot_stomp), 32'(stomp_sum));
      chk("trunc_sum", 32'(tot_trunc), 32'(trunc_sum));
      // Sticky status, mask and level interrupt
      reg_rd(8'h00, 32'h7);
      chk("irq_o", 32'h0, 32'(irq));
      reg_wr(8'h04, 32'h4);
      chk("irq_o", 32'h1, 32'(irq));
      reg_wr(8'h00, 32'h4);
      chk("irq_o", 32'h0, 32'(irq));
      reg_rd(8'h00, 32'h3);
      // Every combination of fault sources
      for (int c = 0; c < 8; c++) begin
         @(posedge clk_sys_i);
         tp <= c[0];
         aligned <= !c[1];
         ber <= c[2];
         repeat (2) @(posedge clk_sys_i);
         #1 chk("internal_local_fault_o", 32'(c != 0), 32'(fault));
      end
      reg_rd(8'h10, 32'h1);
      wrap_up();
   end
endmodule : testbench

`default_nettype wire
